// >>> hdl/fdt_logic.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - low fault inputs latch into fault register
// - any captured fault sets pending level one
// - standing faults set level one only once
// - vector read clears serviced pending bit
// - clear fault command rearms level one
// - faults 0,5,8 assert instruction abort
// - faults 0,5,8 blocked while buffers disabled
// - sixteen levels, zero highest, encoded
// - dma requests ignored unless permit high
// - grant low on edge after request
// - grant drives direction and disable low
// - request release drops grant next edge
// - hold lowers buffers, resets watchdog
// - timer a ticks, timer b tick/10
// - overflow sets levels seven and nine
// - freeze holds timers, blocks timer commands
// - freeze forces permit low, grant high
// - trigger counts own clock, freezable
// - trigger overflow holds expired low
// - watchdog starts on strobe, ready low stops it
// - watchdog timeout sets fault 3 or 5
// - watchdog off on disable, dma, hold
module fdt_logic
  import fdt_pkg::*;
#(
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // faults
  input  wire logic [7:0]  fault_n_i,
  input  wire logic        ext_address_error_in_n_i,
  input  wire logic        memory_protect_error_in_n_i,
  output logic             instruction_abort_out_n_o,
  output logic             irq_n_o,
  // dma and hold
  input  wire logic        dma_request_in_n_i,
  input  wire logic        hold_grant_in_n_i,
  output logic             dma_permit_out_o,
  output logic             dma_grant_out_n_o,
  output logic             data_direction_out_n_o,
  output logic             control_buffer_disable_n_o,
  // timers
  input  wire logic        timer_tick_in_i,
  input  wire logic        timer_freeze_in_n_i,
  input  wire logic        trigger_count_clock_i,
  output logic             trigger_expired_out_n_o,
  // watchdog
  input  wire logic        data_strobe_in_n_i,
  input  wire logic        mem_cycle_i,
  input  wire logic        external_ready_in_n_i,
  input  wire logic        timeout_disable_in_n_i
);
  initial begin
    if (TW < 2 || TW > 16) $error("fdt_logic: TW must be 2..16");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0]   fault;
    logic [15:0]   pend;
    logic [15:0]   mask;
    logic          int_en;
    logic          armed;
    logic          abort;
    logic          permit;
    logic          grant;
    logic [TW-1:0] ta;
    logic [TW-1:0] tb;
    logic [TW-1:0] tg;
    logic          ta_run;
    logic          tb_run;
    logic          tg_exp;
    logic [3:0]    div;
    logic          tick_d;
    logic          trigger_count_clock_d;
    logic          ds_d;
    logic          wd_on;
    logic          wd_mem;
    logic [1:0]    wd_ticks;
    logic [15:0]   rdata;
  } fdt_state_t;

  fdt_state_t st;
  fdt_state_t next_st;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [4:0] fdt_prio(input logic [15:0] v);
    fdt_prio = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) fdt_prio = 5'(i);
    end
  endfunction : fdt_prio

  logic        hold_act;
  logic        buf_dis;
  logic        frozen;
  logic [15:0] ready_int;
  logic [4:0]  vec;
  logic        tick_edge;
  logic        tb_edge;
  logic        tg_edge;
  logic [15:0] cap;
  logic        wd_timeout;

  always_comb begin
    hold_act  = !hold_grant_in_n_i;
    buf_dis   = st.grant || hold_act;
    frozen    = !timer_freeze_in_n_i;
    ready_int = st.pend & (st.mask | UNMASKABLE) &
                (st.int_en ? 16'hffff : UNDISABLE);
    vec       = fdt_prio(ready_int);
    tick_edge = timer_tick_in_i && !st.tick_d;
    tb_edge   = tick_edge && (st.div == 4'(TB_DIVIDE - 1));
    tg_edge   = trigger_count_clock_i && !st.trigger_count_clock_d;
    cap       = 16'h0000;
    cap[7:0]  = ~fault_n_i;
    cap[FLT_EXT_ADDR] = cap[FLT_EXT_ADDR] || !ext_address_error_in_n_i;
    cap[FLT_MPROT]    = !memory_protect_error_in_n_i;
    wd_timeout = st.wd_on && st.wd_ticks == 2'h2;
    if (wd_timeout) cap[st.wd_mem ? FLT_MEM_TO : FLT_IO_TO] = 1'b1;
    if (buf_dis) cap = cap & ~ABORT_FLTS;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [15:0] c;
    c = 16'h0000;
    next_st = st;
    if (reg_wr_i && reg_addr_i == ADDR_CMD) c = reg_wdata_i;
    next_st.tick_d  = timer_tick_in_i;
    next_st.trigger_count_clock_d = trigger_count_clock_i;
    next_st.ds_d    = data_strobe_in_n_i;
    next_st.rdata   = 16'h0000;
    // faults and level one
    next_st.fault = st.fault | cap;
    if (c[CMD_CLR_FAULT]) begin
      next_st.fault = cap;
      next_st.armed = 1'b1;
    end
    if (reg_wr_i && reg_addr_i == ADDR_FAULT) next_st.fault = reg_wdata_i;
    next_st.abort = |(cap & ABORT_FLTS);
    // pending clear on vector read, set wins
    if (reg_rd_i && reg_addr_i == ADDR_VECTOR && !vec[4]) begin
      next_st.pend[vec[3:0]] = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == ADDR_PEND) next_st.pend = reg_wdata_i;
    if (|cap && st.armed) begin
      next_st.pend[LVL_MACHINE] = 1'b1;
      next_st.armed = c[CMD_CLR_FAULT];
    end
    if (reg_wr_i && reg_addr_i == ADDR_MASK) next_st.mask = reg_wdata_i;
    if (c[CMD_INT_EN]) next_st.int_en = 1'b1;
    if (c[CMD_INT_DIS]) next_st.int_en = 1'b0;
    // dma
    if (c[CMD_DMA_ON]) next_st.permit = 1'b1;
    if (c[CMD_DMA_OFF]) next_st.permit = 1'b0;
    next_st.grant = !dma_request_in_n_i && st.permit && !frozen;
    if (frozen) next_st.grant = 1'b0;
    // timers
    if (!frozen) begin
      if (tick_edge) next_st.div = tb_edge ? 4'h0 : st.div + 4'h1;
      if (st.ta_run && tick_edge) begin
        next_st.ta = st.ta + 1'b1;
        if (&st.ta) next_st.pend[LVL_TIMER_A] = 1'b1;
      end
      if (st.tb_run && tb_edge) begin
        next_st.tb = st.tb + 1'b1;
        if (&st.tb) next_st.pend[LVL_TIMER_B] = 1'b1;
      end
      if (tg_edge && !st.tg_exp) begin
        next_st.tg = st.tg + 1'b1;
        if (&st.tg) next_st.tg_exp = 1'b1;
      end
      if (c[CMD_TA_START]) next_st.ta_run = 1'b1;
      if (c[CMD_TA_STOP]) next_st.ta_run = 1'b0;
      if (c[CMD_TB_START]) next_st.tb_run = 1'b1;
      if (c[CMD_TB_STOP]) next_st.tb_run = 1'b0;
      if (c[CMD_TRIG_GO]) begin
        next_st.tg = '0;
        next_st.tg_exp = 1'b0;
      end
      if (reg_wr_i && reg_addr_i == ADDR_TIMER_A) next_st.ta = TW'(reg_wdata_i);
      if (reg_wr_i && reg_addr_i == ADDR_TIMER_B) next_st.tb = TW'(reg_wdata_i);
      if (reg_wr_i && reg_addr_i == ADDR_TRIGGER) next_st.tg = TW'(reg_wdata_i);
    end
    // watchdog
    if (st.ds_d && !data_strobe_in_n_i) begin
      next_st.wd_on = 1'b1;
      next_st.wd_mem = mem_cycle_i;
      next_st.wd_ticks = 2'h0;
    end else if (st.wd_on && !external_ready_in_n_i) begin
      next_st.wd_on = 1'b0;
    end else if (wd_timeout) begin
      next_st.wd_on = 1'b0;
    end else if (st.wd_on && tick_edge) begin
      next_st.wd_ticks = st.wd_ticks + 2'h1;
    end
    if (!timeout_disable_in_n_i || buf_dis) begin
      next_st.wd_on = 1'b0;
      next_st.wd_ticks = 2'h0;
    end
    // read data
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CTRL:    next_st.rdata = {11'h000, st.tg_exp, st.tb_run,
                                       st.ta_run, st.permit, st.int_en};
        ADDR_FAULT:   next_st.rdata = st.fault;
        ADDR_FPEEK:   next_st.rdata = st.fault;
        ADDR_PEND:    next_st.rdata = st.pend;
        ADDR_MASK:    next_st.rdata = st.mask;
        ADDR_VECTOR:  next_st.rdata = {7'h00, vec[4],
                                       LINK_BASE + {3'h0, vec[3:0], 1'b0}};
        ADDR_TIMER_A: next_st.rdata = 16'(st.ta);
        ADDR_TIMER_B: next_st.rdata = 16'(st.tb);
        ADDR_TRIGGER: next_st.rdata = 16'(st.tg);
        default:      next_st.rdata = 16'h0000;
      endcase
      if (reg_addr_i == ADDR_FAULT) next_st.fault = cap;
      if (reg_addr_i == ADDR_FAULT) next_st.armed = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st        <= '0;
      st.armed  <= 1'b1;
      st.ta_run <= 1'b1;
      st.tb_run <= 1'b1;
      st.tick_d <= 1'b1;
      st.trigger_count_clock_d <= 1'b1;
      st.ds_d   <= 1'b1;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata_o                = st.rdata;
  assign instruction_abort_out_n_o  = !st.abort;
  assign irq_n_o                    = vec[4];
  assign dma_permit_out_o           = st.permit && !frozen;
  assign dma_grant_out_n_o          = !st.grant;
  assign data_direction_out_n_o     = !buf_dis;
  assign control_buffer_disable_n_o = !buf_dis;
  assign trigger_expired_out_n_o    = !st.tg_exp;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  fault_capture_a: assert property (clk_en_i && !fault_n_i[2] |=>
    st.fault[2] || $past(reg_wr_i)) else $error("fault not captured");
  machine_level_a: assert property (clk_en_i && |cap && st.armed
    && !(reg_wr_i && reg_addr_i == ADDR_PEND) |=> st.pend[LVL_MACHINE])
    else $error("level one not set");
  anti_repeat_a: assert property (!st.armed && !reg_rd_i && !reg_wr_i
    && !st.pend[LVL_MACHINE] && |cap |=> !st.pend[LVL_MACHINE])
    else $error("level one repeated");
  abort_out_a: assert property (clk_en_i && |(cap & ABORT_FLTS)
    |=> !instruction_abort_out_n_o) else $error("abort missing");
  abort_block_a: assert property (buf_dis |-> !(|(cap & ABORT_FLTS)))
    else $error("abort fault during dma");
  unmask_a: assert property (st.pend[LVL_POWER] |-> vec == 5'h00)
    else $error("level zero not top");
  grant_gate_a: assert property (!st.permit |=> dma_grant_out_n_o)
    else $error("grant without permit");
  grant_bufs_a: assert property (!dma_grant_out_n_o |->
    !data_direction_out_n_o && !control_buffer_disable_n_o)
    else $error("buffers not low in grant");
  freeze_dma_a: assert property (!timer_freeze_in_n_i |->
    !dma_permit_out_o ##1 (dma_grant_out_n_o || !clk_en_i))
    else $error("freeze did not block dma");
  logic c_go;
  assign c_go = reg_wr_i && reg_addr_i == ADDR_CMD && reg_wdata_i[CMD_TRIG_GO];

  trig_hold_a: assert property (!trigger_expired_out_n_o && !c_go
    |=> !trigger_expired_out_n_o) else $error("trigger released");
  wd_off_a: assert property (!timeout_disable_in_n_i && clk_en_i
    |=> !st.wd_on) else $error("watchdog active when disabled");

  // ************************************************************
  // dma, hold, vector and timer checks
  // ************************************************************
  grant_next_a: assert property (clk_en_i && !dma_request_in_n_i
    && st.permit && timer_freeze_in_n_i |=> !dma_grant_out_n_o)
    else $error("grant not given");
  grant_release_a: assert property (clk_en_i && dma_request_in_n_i
    |=> dma_grant_out_n_o) else $error("grant not released");
  permit_cmd_a: assert property (clk_en_i && c_go_dma_on
    |=> st.permit) else $error("permit not set");
  hold_bufs_a: assert property (!hold_grant_in_n_i |->
    !data_direction_out_n_o && !control_buffer_disable_n_o)
    else $error("buffers not low in hold");
  hold_wd_a: assert property (clk_en_i && !hold_grant_in_n_i
    |=> !st.wd_on) else $error("watchdog active in hold");
  vec_clear_a: assert property (clk_en_i && reg_rd_i
    && reg_addr_i == ADDR_VECTOR && !vec[4] && vec[3:0] == 4'(LVL_POWER)
    && !reg_wr_i |=> !st.pend[LVL_POWER])
    else $error("serviced level not cleared");
  timer_a_ovf_a: assert property (clk_en_i && !frozen && st.ta_run
    && tick_edge && &st.ta |=> st.pend[LVL_TIMER_A])
    else $error("timer a overflow lost");
  timer_b_ovf_a: assert property (clk_en_i && !frozen && st.tb_run
    && tb_edge && &st.tb |=> st.pend[LVL_TIMER_B])
    else $error("timer b overflow lost");
  freeze_hold_a: assert property (clk_en_i && frozen
    |=> st.ta == $past(st.ta) && st.tb == $past(st.tb))
    else $error("timer moved while frozen");
  trig_freeze_a: assert property (clk_en_i && frozen
    |=> st.tg == $past(st.tg)) else $error("trigger moved while frozen");

  logic c_go_dma_on;
  assign c_go_dma_on = reg_wr_i && reg_addr_i == ADDR_CMD
                       && reg_wdata_i[CMD_DMA_ON] && !reg_wdata_i[CMD_DMA_OFF];

  dma_grant_c: cover property (!dma_grant_out_n_o ##1 dma_grant_out_n_o);
  timeout_c:   cover property (wd_timeout);
  trig_exp_c:  cover property ($fell(trigger_expired_out_n_o));
  timer_a_c:   cover property (st.ta_run && tick_edge && &st.ta);
  freeze_c:    cover property (frozen && tick_edge);
endmodule : fdt_logic

// >>> hdl/fdt_pkg.sv
package fdt_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_FAULT    = 4'h1;
  localparam logic [3:0] ADDR_PEND     = 4'h2;
  localparam logic [3:0] ADDR_MASK     = 4'h3;
  localparam logic [3:0] ADDR_VECTOR   = 4'h4;
  localparam logic [3:0] ADDR_TIMER_A  = 4'h5;
  localparam logic [3:0] ADDR_TIMER_B  = 4'h6;
  localparam logic [3:0] ADDR_TRIGGER  = 4'h7;
  localparam logic [3:0] ADDR_CMD      = 4'h8;
  localparam logic [3:0] ADDR_FPEEK    = 4'h9;
  // ************************************************************
  // command word bits (write to ADDR_CMD)
  // ************************************************************
  localparam int CMD_CLR_FAULT = 0;
  localparam int CMD_DMA_ON    = 1;
  localparam int CMD_DMA_OFF   = 2;
  localparam int CMD_TA_START  = 3;
  localparam int CMD_TA_STOP   = 4;
  localparam int CMD_TB_START  = 5;
  localparam int CMD_TB_STOP   = 6;
  localparam int CMD_TRIG_GO   = 7;
  localparam int CMD_INT_EN    = 8;
  localparam int CMD_INT_DIS   = 9;
  // ************************************************************
  // fault bits and levels
  // ************************************************************
  localparam int FLT_EXT_ADDR  = 0;
  localparam int FLT_MEM_TO    = 3;
  localparam int FLT_IO_TO     = 5;
  localparam int FLT_MPROT     = 8;
  localparam int LVL_POWER     = 0;
  localparam int LVL_MACHINE   = 1;
  localparam int LVL_EXEC      = 5;
  localparam int LVL_TIMER_A   = 7;
  localparam int LVL_TIMER_B   = 9;
  localparam logic [15:0] UNMASKABLE  = 16'h0021;
  localparam logic [15:0] UNDISABLE   = 16'h0023;
  localparam logic [15:0] ABORT_FLTS  = 16'h0121;
  localparam logic [15:0] FIXED_FLTS  = 16'h0129;
  localparam logic [7:0]  LINK_BASE   = 8'h20;
  localparam int          TB_DIVIDE   = 10;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS       = 20;
  localparam int TICK_NS      = 10000;
  localparam int TICK_CYCLES  = TICK_NS / CLK_NS;
endpackage : fdt_pkg

// >>> sim/fdt_dma_model.sv
`timescale 1ns/100ps
// ************************************************************
// dma controller model
// ************************************************************
module fdt_dma_model (
  // clock
  input  wire logic       mclk_i,
  // stimulus side
  input  wire logic       go_i,
  input  wire logic [3:0] len_i,
  // bus side
  input  wire logic       grant_n_i,
  output logic            req_n_o
);
  logic [3:0] cnt;
  initial req_n_o = 1'b1;
  always @(posedge mclk_i) begin
    if (go_i && req_n_o) begin
      req_n_o <= 1'b0;
      cnt     <= len_i;
    end else if (!go_i && grant_n_i) begin
      req_n_o <= 1'b1;
    end else if (!req_n_o && !grant_n_i) begin
      if (cnt == 4'h0) req_n_o <= 1'b1;
      else cnt <= cnt - 4'h1;
    end
  end
endmodule : fdt_dma_model

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb
  import fdt_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic        mclk_i = 1'b0;
  logic        reset_i, reg_wr_i, reg_rd_i, rd_d, ab_seen, go, tick_en;
  logic [3:0]  reg_addr_i, len;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [7:0]  fault_n_i;
  logic        ext_address_error_in_n_i, dma_request_in_n_i;
  logic        hold_grant_in_n_i, dma_permit_out_o, dma_grant_out_n_o;
  logic        data_direction_out_n_o, control_buffer_disable_n_o;
  logic        timer_tick_in_i, timer_freeze_in_n_i, trigger_count_clock_i;
  logic        trigger_expired_out_n_o, irq_n_o, instruction_abort_out_n_o;
  logic        data_strobe_in_n_i, mem_cycle_i, external_ready_in_n_i;
  logic        timeout_disable_in_n_i, mp_n;
  logic [19:0] exp_q[$];
  logic [19:0] e;
  int          n_mismatch, tests_run, cyc, k;
  logic [2:0]  wd[4] = '{3'b111, 3'b011, 3'b101, 3'b110};
  logic [15:0] wd_x[4] = '{16'h0008, 16'h0020, 16'h0000, 16'h0000};

  fdt_logic i_dut (.mclk_i, .reset_i, .clk_en_i(1'b1), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fault_n_i,
    .ext_address_error_in_n_i, .memory_protect_error_in_n_i(mp_n),
    .instruction_abort_out_n_o, .irq_n_o, .dma_request_in_n_i,
    .hold_grant_in_n_i, .dma_permit_out_o, .dma_grant_out_n_o,
    .data_direction_out_n_o, .control_buffer_disable_n_o, .timer_tick_in_i,
    .timer_freeze_in_n_i, .trigger_count_clock_i, .trigger_expired_out_n_o,
    .data_strobe_in_n_i, .mem_cycle_i, .external_ready_in_n_i,
    .timeout_disable_in_n_i);
  fdt_dma_model i_dma (.mclk_i, .go_i(go), .len_i(len),
    .grant_n_i(dma_grant_out_n_o), .req_n_o(dma_request_in_n_i));

  // ************************************************************
  // clock, tick, monitor, timeout
  // ************************************************************
  always #10 mclk_i = ~mclk_i;
  always begin
    repeat (5) @(posedge mclk_i);
    if (tick_en) timer_tick_in_i <= ~timer_tick_in_i;
  end
  always @(posedge mclk_i) begin
    rd_d <= reg_rd_i;
    if (!instruction_abort_out_n_o) ab_seen <= 1'b1;
    if (rd_d) begin
      e = exp_q.pop_front();
      check($sformatf("read %h", e[19:16]), reg_rdata_o, e[15:0]);
    end
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    reg_rd_i    <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    reg_wr_i   <= 1'b0;
    exp_q.push_back({a, x});
    @(posedge mclk_i);
  endtask : rd
  task automatic idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
  endtask : idle
  task automatic pin(input string what, input logic s, x);
    check(what, {15'h0, s}, {15'h0, x});
  endtask : pin
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {reset_i, ext_address_error_in_n_i, hold_grant_in_n_i} = 3'b111;
    {timer_freeze_in_n_i, data_strobe_in_n_i, tick_en} = 3'b111;
    {external_ready_in_n_i, timeout_disable_in_n_i} = 2'b11;
    {reg_wr_i, reg_rd_i, rd_d, ab_seen, go, mem_cycle_i} = 6'h0;
    {timer_tick_in_i, trigger_count_clock_i, len, reg_addr_i} = 10'h0;
    {reg_wdata_i, fault_n_i} = {16'h0, 8'hff};
    mp_n = 1'b1;
    k = $urandom(32'hf8db237a);
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd(ADDR_CTRL, 16'h000c);
    rd(ADDR_PEND, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(ADDR_MASK, 16'hffff);
    ext_address_error_in_n_i <= 1'b0;
    fault_n_i <= 8'($urandom);
    idle(3);
    pin("abort", ab_seen, 1'b1);
    rd(ADDR_PEND, 16'h0002);
    rd(ADDR_VECTOR, 16'h0022);
    idle(2);
    rd(ADDR_PEND, 16'h0000);
    {ext_address_error_in_n_i, fault_n_i} <= 9'h1ff;
    wr(ADDR_CMD, 16'h0001 << CMD_CLR_FAULT);
    idle(2);
    rd(ADDR_FPEEK, 16'h0000);
    ext_address_error_in_n_i <= 1'b0;
    idle(1);
    ext_address_error_in_n_i <= 1'b1;
    idle(2);
    rd(ADDR_FPEEK, 16'h0001);
    rd(ADDR_VECTOR, 16'h0022);
    wr(ADDR_CMD, 16'h0001 << CMD_CLR_FAULT);
    $display("test faults done");
    {ab_seen, hold_grant_in_n_i, ext_address_error_in_n_i, mp_n} <= 4'h0;
    idle(3);
    pin("dir", data_direction_out_n_o, 1'b0);
    pin("dis", control_buffer_disable_n_o, 1'b0);
    pin("abort", ab_seen, 1'b0);
    {hold_grant_in_n_i, ext_address_error_in_n_i, mp_n} <= 3'b111;
    idle(2);
    pin("dir", data_direction_out_n_o, 1'b1);
    rd(ADDR_FPEEK, 16'h0000);
    go <= 1'b1;
    idle(4);
    pin("grant", dma_grant_out_n_o, 1'b1);
    go <= 1'b0;
    wr(ADDR_CMD, 16'h0001 << CMD_DMA_ON);
    rd(ADDR_CTRL, 16'h000e);
    len <= 4'($urandom_range(7));
    go  <= 1'b1;
    idle(3);
    pin("grant", dma_grant_out_n_o, 1'b0);
    pin("dis", control_buffer_disable_n_o, 1'b0);
    pin("dir", data_direction_out_n_o, 1'b0);
    go <= 1'b0;
    for (k = 0; k < 12 && !dma_grant_out_n_o; k++) idle(1);
    pin("grant", dma_grant_out_n_o, 1'b1);
    pin("dis", control_buffer_disable_n_o, 1'b1);
    {timer_freeze_in_n_i, go} <= 2'b01;
    idle(4);
    pin("permit", dma_permit_out_o, 1'b0);
    pin("grant", dma_grant_out_n_o, 1'b1);
    {timer_freeze_in_n_i, go} <= 2'b10;
    $display("test dma done");
    wr(ADDR_PEND, 16'h0000);
    wr(ADDR_TIMER_A, 16'hffff);
    wr(ADDR_TIMER_B, 16'hffff);
    idle(120);
    rd(ADDR_PEND, 16'h0280);
    tick_en <= 1'b0;
    wr(ADDR_TIMER_A, 16'h0100);
    timer_freeze_in_n_i <= 1'b0;
    wr(ADDR_TIMER_A, 16'h1234);
    tick_en <= 1'b1;
    idle(40);
    rd(ADDR_TIMER_A, 16'h0100);
    timer_freeze_in_n_i <= 1'b1;
    wr(ADDR_CMD, 16'h0001 << CMD_INT_EN);
    wr(ADDR_MASK, 16'hffff);
    wr(ADDR_PEND, 16'h0280);
    rd(ADDR_VECTOR, 16'h002e);
    rd(ADDR_VECTOR, 16'h0032);
    wr(ADDR_MASK, 16'h0000);
    wr(ADDR_PEND, 16'h0021);
    idle(1);
    pin("irq", irq_n_o, 1'b0);
    rd(ADDR_VECTOR, 16'h0020);
    rd(ADDR_VECTOR, 16'h002a);
    wr(ADDR_TRIGGER, 16'hffff);
    trigger_count_clock_i <= 1'b1;
    idle(3);
    pin("trig", trigger_expired_out_n_o, 1'b0);
    trigger_count_clock_i <= 1'b0;
    wr(ADDR_CMD, 16'h0001 << CMD_TRIG_GO);
    idle(2);
    pin("trig", trigger_expired_out_n_o, 1'b1);
    $display("test timers done");
    for (int i = 0; i < 4; i++) begin
      {mem_cycle_i, timeout_disable_in_n_i, external_ready_in_n_i} <= wd[i];
      data_strobe_in_n_i <= 1'b0;
      idle(45);
      rd(ADDR_FPEEK, wd_x[i]);
      data_strobe_in_n_i <= 1'b1;
      wr(ADDR_CMD, 16'h0001 << CMD_CLR_FAULT);
      idle(2);
    end
    $display("test watchdog done");
    idle(3);
    print_verdict();
  end
endmodule : tb
